// ==== hdl/gpeb_pkg.sv ====
// Package for the eight-line I/O port with edge interrupts.
// Assumes a 16-bit register port addressed by byte offset, word access only.
package gpeb_pkg;

    localparam int unsigned PIN_W = 8;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 16;

    // Register byte offsets
    localparam logic [4:0] OFF_PIN_LEVEL_INPUT = 5'h00;
    localparam logic [4:0] OFF_OUTPUT_VALUE = 5'h02;
    localparam logic [4:0] OFF_PIN_DIRECTION = 5'h04;
    localparam logic [4:0] OFF_PULL_RESISTOR_ENABLE = 5'h06;
    localparam logic [4:0] OFF_DRIVE_STRENGTH_SELECT = 5'h08;
    localparam logic [4:0] OFF_PIN_FUNCTION_SELECT = 5'h0A;
    localparam logic [4:0] OFF_PORT_IRQ_VECTOR = 5'h0E;
    localparam logic [4:0] OFF_EDGE_POLARITY_SELECT = 5'h18;
    localparam logic [4:0] OFF_EDGE_IRQ_ENABLE = 5'h1A;
    localparam logic [4:0] OFF_EDGE_PENDING_FLAGS = 5'h1C;

    // Reset values
    localparam logic [7:0] RST_OUTPUT_VALUE = 8'h00;
    localparam logic [7:0] RST_PIN_DIRECTION = 8'h00;
    localparam logic [7:0] RST_PULL_RESISTOR_ENABLE = 8'h00;
    localparam logic [7:0] RST_DRIVE_STRENGTH_SELECT = 8'h00;
    localparam logic [7:0] RST_PIN_FUNCTION_SELECT = 8'h00;
    localparam logic [7:0] RST_EDGE_POLARITY_SELECT = 8'h00;
    localparam logic [7:0] RST_EDGE_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RST_EDGE_PENDING_FLAGS = 8'h00;
    localparam logic [7:0] RST_PERIPH_INPUT = 8'h00;

    // Vector encoding: none pending, then step per bit
    localparam logic [15:0] IRQ_VECTOR_NONE = 16'h0000;
    localparam logic [15:0] IRQ_VECTOR_STEP = 16'h0002;

endpackage

// ==== hdl/gpeb_port.sv ====
// Eight-line I/O port with per-pin edge interrupts and a priority vector.
// Assumes pin inputs arrive asynchronously and are synchronised here, a
// word-wide register port with one-cycle strobes, and a CPU that supplies
// its global interrupt enable as a level.
module gpeb_port
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Register port
    input wire logic [4:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    output logic [15:0] o_rdata,
    // CPU
    input wire logic i_global_irq_enable,
    output logic o_irq,
    // Pins
    input wire logic [7:0] i_pin,
    output logic [7:0] o_pin_out,
    output logic [7:0] o_pin_oe,
    output logic [7:0] o_pull_en,
    output logic [7:0] o_pull_up,
    output logic [7:0] o_drive_full,
    // Multiplexed peripheral
    input wire logic [7:0] i_periph_out,
    output logic [7:0] o_periph_in
);

    logic [7:0] output_value_r;
    logic [7:0] pin_direction_r;
    logic [7:0] pull_resistor_enable_r;
    logic [7:0] drive_strength_select_r;
    logic [7:0] pin_function_select_r;
    logic [7:0] edge_polarity_select_r;
    logic [7:0] edge_irq_enable_r;
    logic [7:0] edge_pending_flags_r;
    logic [7:0] edge_pending_flags_nxt;
    logic [7:0] sync_meta_r;
    logic [7:0] sync_pin_r;
    logic [7:0] edge_sig_prev_r;
    logic [7:0] edge_sig;
    logic [7:0] edge_hit;
    logic [7:0] periph_in_r;
    logic [15:0] rdata_r;
    logic [15:0] irq_vector;
    logic [7:0] vector_clear;
    logic [7:0] active;
    logic wr_hit;
    logic iv_access;

    assign wr_hit = i_ce && i_we;
    // Both reads and writes of the vector acknowledge; the bus is word-only
    assign iv_access = i_ce && (i_we || i_re) && (i_addr == gpeb_pkg::OFF_PORT_IRQ_VECTOR);

    // Configuration registers
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            output_value_r <= gpeb_pkg::RST_OUTPUT_VALUE;
            pin_direction_r <= gpeb_pkg::RST_PIN_DIRECTION;
            pull_resistor_enable_r <= gpeb_pkg::RST_PULL_RESISTOR_ENABLE;
            drive_strength_select_r <= gpeb_pkg::RST_DRIVE_STRENGTH_SELECT;
            pin_function_select_r <= gpeb_pkg::RST_PIN_FUNCTION_SELECT;
            edge_polarity_select_r <= gpeb_pkg::RST_EDGE_POLARITY_SELECT;
            edge_irq_enable_r <= gpeb_pkg::RST_EDGE_IRQ_ENABLE;
        end
        else if (wr_hit)
        begin
            unique case (i_addr)
                gpeb_pkg::OFF_OUTPUT_VALUE: output_value_r <= i_wdata[7:0];
                gpeb_pkg::OFF_PIN_DIRECTION: pin_direction_r <= i_wdata[7:0];
                gpeb_pkg::OFF_PULL_RESISTOR_ENABLE: pull_resistor_enable_r <= i_wdata[7:0];
                gpeb_pkg::OFF_DRIVE_STRENGTH_SELECT: drive_strength_select_r <= i_wdata[7:0];
                // Function select never touches direction
                gpeb_pkg::OFF_PIN_FUNCTION_SELECT: pin_function_select_r <= i_wdata[7:0];
                gpeb_pkg::OFF_EDGE_POLARITY_SELECT: edge_polarity_select_r <= i_wdata[7:0];
                gpeb_pkg::OFF_EDGE_IRQ_ENABLE: edge_irq_enable_r <= i_wdata[7:0];
                default: ;
            endcase
        end
    end

    // Two-flop synchroniser, then the polarity-adjusted level is remembered
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sync_meta_r <= 8'h00;
            sync_pin_r <= 8'h00;
            edge_sig_prev_r <= 8'h00;
        end
        else if (i_ce)
        begin
            sync_meta_r <= i_pin;
            sync_pin_r <= sync_meta_r;
            edge_sig_prev_r <= edge_sig;
        end
    end

    // Inverting by polarity turns either chosen edge into a rise; a polarity
    // change while the level matches also shows as a rise
    assign edge_sig = sync_pin_r ^ edge_polarity_select_r;
    // Pin changes caused by our own output/direction/pull writes are seen
    // through the pin and may set flags
    assign edge_hit = edge_sig & ~edge_sig_prev_r & ~pin_function_select_r;

    assign active = edge_pending_flags_r & edge_irq_enable_r;

    // Priority encode, bit 0 highest
    always_comb
    begin
        irq_vector = gpeb_pkg::IRQ_VECTOR_NONE;
        vector_clear = 8'h00;
        for (int i = gpeb_pkg::PIN_W - 1; i >= 0; i--)
        begin
            if (active[i])
            begin
                irq_vector = gpeb_pkg::IRQ_VECTOR_STEP * 16'(i + 1);
                vector_clear = 8'h01 << i;
            end
        end
    end

    // Pending flags: a hardware set always wins over any clear
    always_comb
    begin
        edge_pending_flags_nxt = edge_pending_flags_r;
        if (wr_hit && i_addr == gpeb_pkg::OFF_EDGE_PENDING_FLAGS)
            edge_pending_flags_nxt = i_wdata[7:0];
        if (iv_access)
            edge_pending_flags_nxt = edge_pending_flags_nxt & ~vector_clear;
        edge_pending_flags_nxt = edge_pending_flags_nxt | edge_hit;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            edge_pending_flags_r <= gpeb_pkg::RST_EDGE_PENDING_FLAGS;
        else if (i_ce)
            edge_pending_flags_r <= edge_pending_flags_nxt;
    end

    // Peripheral input follows the pin only while selected, otherwise holds
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            periph_in_r <= gpeb_pkg::RST_PERIPH_INPUT;
        else if (i_ce)
            periph_in_r <= (sync_pin_r & pin_function_select_r)
                | (periph_in_r & ~pin_function_select_r);
    end

    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            rdata_r <= 16'h0000;
        else if (i_ce)
        begin
            rdata_r <= 16'h0000;
            if (i_re)
            begin
                unique case (i_addr)
                    gpeb_pkg::OFF_PIN_LEVEL_INPUT: rdata_r <= {8'h00, sync_pin_r};
                    gpeb_pkg::OFF_OUTPUT_VALUE: rdata_r <= {8'h00, output_value_r};
                    gpeb_pkg::OFF_PIN_DIRECTION: rdata_r <= {8'h00, pin_direction_r};
                    gpeb_pkg::OFF_PULL_RESISTOR_ENABLE: rdata_r <= {8'h00, pull_resistor_enable_r};
                    gpeb_pkg::OFF_DRIVE_STRENGTH_SELECT: rdata_r <= {8'h00, drive_strength_select_r};
                    gpeb_pkg::OFF_PIN_FUNCTION_SELECT: rdata_r <= {8'h00, pin_function_select_r};
                    gpeb_pkg::OFF_PORT_IRQ_VECTOR: rdata_r <= irq_vector;
                    gpeb_pkg::OFF_EDGE_POLARITY_SELECT: rdata_r <= {8'h00, edge_polarity_select_r};
                    gpeb_pkg::OFF_EDGE_IRQ_ENABLE: rdata_r <= {8'h00, edge_irq_enable_r};
                    gpeb_pkg::OFF_EDGE_PENDING_FLAGS: rdata_r <= {8'h00, edge_pending_flags_r};
                    default: rdata_r <= 16'h0000;
                endcase
            end
        end
    end

    assign o_rdata = rdata_r;
    // Request stays up while any enabled flag remains, so a later flag re-requests
    assign o_irq = (|active) && i_global_irq_enable;

    // Pin drive: direction governs both functions
    assign o_pin_oe = pin_direction_r;
    assign o_pin_out = (output_value_r & ~pin_function_select_r)
        | (i_periph_out & pin_function_select_r);
    // Pull only on inputs of the port function; output wins
    assign o_pull_en = pull_resistor_enable_r & ~pin_direction_r & ~pin_function_select_r;
    assign o_pull_up = output_value_r;
    assign o_drive_full = drive_strength_select_r;
    assign o_periph_in = periph_in_r;

    // Checks
    logic [7:0] sync_prev_r;
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            sync_prev_r <= 8'h00;
        else if (i_ce)
            sync_prev_r <= sync_pin_r;
    end

    irq_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_irq == ((|(edge_pending_flags_r & edge_irq_enable_r)) && i_global_irq_enable))
        else $error("interrupt request not gated by enables");

    flag_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && edge_hit[0]) |=> edge_pending_flags_r[0])
        else $error("edge did not set pending flag");

    sel_block_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && pin_function_select_r[7] && !(wr_hit && i_addr == gpeb_pkg::OFF_EDGE_PENDING_FLAGS)
        && !edge_pending_flags_r[7]) |=> !edge_pending_flags_r[7])
        else $error("peripheral pin raised a flag");

    vec_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_re && i_addr == gpeb_pkg::OFF_PORT_IRQ_VECTOR && active == 8'h00)
        |=> o_rdata == 16'h0000)
        else $error("vector not zero with nothing pending");

    vec_bit0_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_re && i_addr == gpeb_pkg::OFF_PORT_IRQ_VECTOR && active[0])
        |=> o_rdata == 16'h0002)
        else $error("bit 0 vector wrong");

    vec_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (iv_access && active[1] && !active[0] && !edge_hit[1]
        && !(wr_hit && i_addr == gpeb_pkg::OFF_EDGE_PENDING_FLAGS))
        |=> !edge_pending_flags_r[1])
        else $error("vector access did not clear flag");

    rising_edge_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !edge_polarity_select_r[2] && sync_pin_r[2] && !sync_prev_r[2]
        && !pin_function_select_r[2] && $stable(edge_polarity_select_r))
        |=> edge_pending_flags_r[2])
        else $error("rising edge missed");

    out_drive_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !pin_function_select_r[5] |-> (o_pin_out[5] == output_value_r[5]))
        else $error("pin output does not follow value");

    pull_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        pin_direction_r[6] |-> !o_pull_en[6])
        else $error("pull enabled on output");

    periph_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !pin_function_select_r[4]) |=> $stable(o_periph_in[4]))
        else $error("peripheral input moved while deselected");

    periph_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && pin_function_select_r[4]) |=> (o_periph_in[4] == $past(sync_pin_r[4])))
        else $error("peripheral input does not follow pin");

    oe_dir_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_pin_oe == pin_direction_r)
        else $error("output enable differs from direction");

    drive_reset_a: assert property (@(posedge i_clk)
        $past(i_rst) |-> (o_drive_full == 8'h00))
        else $error("drive strength not reduced after reset");

    pull_type_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_pull_en[0] && !o_pull_up[0]) |-> !output_value_r[0])
        else $error("pull type does not follow value bit");

    pull_on_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (pull_resistor_enable_r[0] && !pin_direction_r[0] && !pin_function_select_r[0])
        |-> o_pull_en[0])
        else $error("pull not enabled on input");

    periph_drive_a: assert property (@(posedge i_clk) disable iff (i_rst)
        pin_function_select_r[6] |-> (o_pin_out[6] == i_periph_out[6]))
        else $error("peripheral value not on pin");

    dir_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_hit && i_addr == gpeb_pkg::OFF_PIN_FUNCTION_SELECT) |=> $stable(pin_direction_r))
        else $error("function select changed direction");

    level_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_re && i_addr == gpeb_pkg::OFF_PIN_LEVEL_INPUT)
        |=> (o_rdata == {8'h00, $past(sync_pin_r)}))
        else $error("level register does not show pins");

    sw_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_hit && i_addr == gpeb_pkg::OFF_EDGE_PENDING_FLAGS && i_wdata[2])
        |=> edge_pending_flags_r[2])
        else $error("software set of flag lost");

    // A clear flag may only rise through an edge or a software write
    no_static_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !edge_hit[6] && !(wr_hit && i_addr == gpeb_pkg::OFF_EDGE_PENDING_FLAGS)
        && !edge_pending_flags_r[6]) |=> !edge_pending_flags_r[6])
        else $error("flag set without an edge");

    irq_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_global_irq_enable |-> !o_irq)
        else $error("request without global enable");

    irq_mask_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (edge_irq_enable_r == 8'h00) |-> !o_irq)
        else $error("request with all enables off");

    falling_edge_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && edge_polarity_select_r[3] && !sync_pin_r[3] && sync_prev_r[3]
        && !pin_function_select_r[3] && $stable(edge_polarity_select_r))
        |=> edge_pending_flags_r[3])
        else $error("falling edge missed");

    // Polarity raised over a low input counts as an edge
    pol_change_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !pin_function_select_r[0] && $rose(edge_polarity_select_r[0])
        && !sync_pin_r[0] && (sync_prev_r[0] == sync_pin_r[0]))
        |=> edge_pending_flags_r[0])
        else $error("polarity change did not set flag");

endmodule // gpeb_port

// ==== sim/gpeb_pad_model.sv ====
// Pad model for the eight pins: port drive, far-side drive and pull resistors.
// Assumes the bench supplies the far-side drive; a pin nobody holds toggles.
module gpeb_pad_model
(
    input wire logic i_clk,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_pull_en,
    input wire logic [7:0] i_pull_up,
    input wire logic [7:0] i_ext_en,
    input wire logic [7:0] i_ext_val,
    output logic [7:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // A floating pin must not read as a stable level
    logic [7:0] float_r = 8'h00;
    always @(posedge i_clk) float_r <= ~float_r;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (i_oe[i])
                o_pin[i] = i_out[i];
            else if (i_ext_en[i])
                o_pin[i] = i_ext_val[i];
            else if (i_pull_en[i])
                o_pin[i] = i_pull_up[i];
            else
                o_pin[i] = float_r[i];
        end
    end
endmodule // gpeb_pad_model

// ==== sim/testbench.sv ====
// Self-checking bench for the I/O port: register port, pads and edge flags.
// Assumes one 100 MHz clock; read results are queued and checked by a monitor.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [4:0] i_addr = 5'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic i_we = 1'b0;
    logic i_re = 1'b0;
    logic global_irq_enable = 1'b1;
    logic ce = 1'b1;
    logic [7:0] periph_out = 8'h00;
    logic [7:0] ext_en = 8'hFF;
    logic [7:0] ext_val = 8'h00;
    logic [15:0] o_rdata;
    logic o_irq;
    logic [7:0] pin, pin_out, pin_oe, pull_en, pull_up, drive_full, periph_in;
    int errors = 0;
    int checked = 0;
    int seed = 32'hD49B;
    logic [15:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic [7:0] rv;
    logic [4:0] offs [8] = '{gpeb_pkg::OFF_OUTPUT_VALUE, gpeb_pkg::OFF_PIN_DIRECTION,
        gpeb_pkg::OFF_PULL_RESISTOR_ENABLE, gpeb_pkg::OFF_DRIVE_STRENGTH_SELECT,
        gpeb_pkg::OFF_PIN_FUNCTION_SELECT, gpeb_pkg::OFF_EDGE_POLARITY_SELECT,
        gpeb_pkg::OFF_EDGE_IRQ_ENABLE, gpeb_pkg::OFF_EDGE_PENDING_FLAGS};

    always #5 i_clk = ~i_clk;

    gpeb_port uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
        .i_global_irq_enable(global_irq_enable), .o_irq(o_irq), .i_pin(pin), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe), .o_pull_en(pull_en), .o_pull_up(pull_up),
        .o_drive_full(drive_full), .i_periph_out(periph_out), .o_periph_in(periph_in));

    gpeb_pad_model pads (.i_clk(i_clk), .i_oe(pin_oe), .i_out(pin_out),
        .i_pull_en(pull_en), .i_pull_up(pull_up), .i_ext_en(ext_en),
        .i_ext_val(ext_val), .o_pin(pin));

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= {8'h00, d};
        i_we <= 1'b1;
        @(posedge i_clk);
        i_we <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge i_clk);
        exp_q.push_back(e);
        i_addr <= a;
        i_re <= 1'b1;
        @(posedge i_clk);
        i_re <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge i_clk)
    begin
        if (rd_seen)
            cmp(o_rdata, exp_q.pop_front());
        rd_seen <= i_re;
    end

    initial
    begin
        repeat (5000) @(posedge i_clk);
        errors++;
        give_verdict();
    end

    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (offs[k]) rd(offs[k], 16'h0000);
        rd(gpeb_pkg::OFF_PORT_IRQ_VECTOR, gpeb_pkg::IRQ_VECTOR_NONE);
        rd(5'h10, 16'h0000);
        foreach (offs[k])
        begin
            rv = 8'($random(seed));
            wr(offs[k], rv);
            rd(offs[k], {8'h00, rv});
        end
        foreach (offs[k]) wr(offs[k], 8'h00);
        rd(gpeb_pkg::OFF_EDGE_PENDING_FLAGS, 16'h0000);
        // Output drive, loopback through the pads
        rv = 8'($random(seed));
        wr(gpeb_pkg::OFF_OUTPUT_VALUE, rv);
        wr(gpeb_pkg::OFF_PIN_DIRECTION, 8'hFF);
        wr(gpeb_pkg::OFF_DRIVE_STRENGTH_SELECT, 8'h3C);
        @(negedge i_clk);
        cmp({8'h00, pin_oe}, 16'h00FF);
        cmp({8'h00, pin_out}, {8'h00, rv});
        cmp({8'h00, drive_full}, 16'h003C);
        rd(gpeb_pkg::OFF_PIN_LEVEL_INPUT, {8'h00, rv});
        // Pulls on inputs, far side holds the upper half low
        ext_en <= 8'hF0;
        wr(gpeb_pkg::OFF_OUTPUT_VALUE, 8'h0F);
        wr(gpeb_pkg::OFF_PULL_RESISTOR_ENABLE, 8'hFF);
        wr(gpeb_pkg::OFF_PIN_DIRECTION, 8'h00);
        @(negedge i_clk);
        cmp({pull_en, pull_up}, 16'hFF0F);
        repeat (3) @(posedge i_clk);
        rd(gpeb_pkg::OFF_PIN_LEVEL_INPUT, 16'h000F);
        wr(gpeb_pkg::OFF_PIN_DIRECTION, 8'hFF);
        @(negedge i_clk);
        cmp({8'h00, pull_en}, 16'h0000);
        // Peripheral function on the upper half
        ext_en <= 8'hFF;
        ext_val <= 8'h50;
        periph_out <= 8'hA5;
        wr(gpeb_pkg::OFF_OUTPUT_VALUE, 8'h00);
        wr(gpeb_pkg::OFF_PIN_DIRECTION, 8'h0F);
        wr(gpeb_pkg::OFF_PIN_FUNCTION_SELECT, 8'hF0);
        @(negedge i_clk);
        cmp({8'h00, pin_out}, 16'h00A0);
        rd(gpeb_pkg::OFF_PIN_DIRECTION, 16'h000F);
        repeat (3) @(posedge i_clk);
        cmp({8'h00, periph_in & 8'hF0}, 16'h0050);
        wr(gpeb_pkg::OFF_PIN_FUNCTION_SELECT, 8'h00);
        ext_val <= 8'hA0;
        repeat (4) @(posedge i_clk);
        cmp({8'h00, periph_in & 8'hF0}, 16'h0050);
        // Edge flags: bit 3 falling, bit 5 disabled, bit 7 given to peripheral
        ext_val <= 8'h00;
        wr(gpeb_pkg::OFF_PIN_DIRECTION, 8'h00);
        wr(gpeb_pkg::OFF_PULL_RESISTOR_ENABLE, 8'h00);
        wr(gpeb_pkg::OFF_PIN_FUNCTION_SELECT, 8'h80);
        wr(gpeb_pkg::OFF_EDGE_POLARITY_SELECT, 8'h08);
        wr(gpeb_pkg::OFF_EDGE_IRQ_ENABLE, 8'hDF);
        repeat (3) @(posedge i_clk);
        wr(gpeb_pkg::OFF_EDGE_PENDING_FLAGS, 8'h00);
        ext_val <= 8'hFF;
        repeat (4) @(posedge i_clk);
        cmp({15'h0000, o_irq}, 16'h0001);
        rd(gpeb_pkg::OFF_EDGE_PENDING_FLAGS, 16'h0077);
        foreach (offs[k])
            if (k < 6)
                rd(gpeb_pkg::OFF_PORT_IRQ_VECTOR, 16'({4'h2, 4'h4, 4'h6, 4'hA, 4'hE, 4'h0} >> (20 - 4 * k)) & 16'h000F);
        rd(gpeb_pkg::OFF_EDGE_PENDING_FLAGS, 16'h0020);
        @(negedge i_clk);
        cmp({15'h0000, o_irq}, 16'h0000);
        ext_val <= 8'h00;
        global_irq_enable <= 1'b0;
        repeat (4) @(posedge i_clk);
        cmp({15'h0000, o_irq}, 16'h0000);
        global_irq_enable <= 1'b1;
        @(negedge i_clk);
        cmp({15'h0000, o_irq}, 16'h0001);
        wr(gpeb_pkg::OFF_PORT_IRQ_VECTOR, 8'h00);
        rd(gpeb_pkg::OFF_EDGE_PENDING_FLAGS, 16'h0020);
        wr(gpeb_pkg::OFF_EDGE_PENDING_FLAGS, 8'hA0);
        rd(gpeb_pkg::OFF_PORT_IRQ_VECTOR, 16'h0010);
        // Clock enable low: the write strobe must be ignored
        ce <= 1'b0;
        wr(gpeb_pkg::OFF_OUTPUT_VALUE, 8'h5A);
        ce <= 1'b1;
        rd(gpeb_pkg::OFF_OUTPUT_VALUE, 16'h0000);
        rd(gpeb_pkg::OFF_EDGE_PENDING_FLAGS, 16'h0020);
        repeat (4) @(posedge i_clk);
        give_verdict();
    end
endmodule // testbench
